// *** inc/sfl_pkg.sv ***
// Constants and types shared by the serial status flag block
`default_nettype none
package sfl_pkg;
  // ----------------------------------------------------------------
  // Register word indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 3;
  localparam logic [2:0]  IDX_CTRL     = 3'h0;
  localparam logic [2:0]  IDX_STATUS   = 3'h3;
  localparam logic [2:0]  IDX_MATCH    = 3'h4;
  localparam logic [2:0]  IDX_DATA     = 3'h5;
  localparam logic [2:0]  IDX_INT_STAT = 3'h6;
  localparam logic [2:0]  IDX_INT_MASK = 3'h7;
  // ----------------------------------------------------------------
  // Status bit positions and reset values
  // ----------------------------------------------------------------
  localparam int          RXF_BIT      = 7;
  localparam int          MATCH_BIT    = 6;
  localparam int          TXE_BIT      = 5;
  localparam int          FAULT_BIT    = 4;
  localparam logic [3:0]  STAT_RSVD    = 4'h0;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  // ----------------------------------------------------------------
  // Interrupt bit positions
  // ----------------------------------------------------------------
  localparam int          INT_W        = 4;
  localparam int          INT_RX       = 0;
  localparam int          INT_MATCH    = 1;
  localparam int          INT_TXE      = 2;
  localparam int          INT_FAULT    = 3;
  // Last bit index of a frame
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] spare;
    logic       master_select;
    logic       fault_detect_enable;
    logic       select_output_enable;
  } sfl_ctrl_t;
  typedef struct packed {
    logic ss_n;
    logic sck;
    logic mosi;
  } sfl_link_t;
  localparam sfl_link_t LINK_IDLE = 3'h4;
  typedef enum {BUS_IDLE, BUS_ACK} sfl_bus_t;
endpackage
`default_nettype wire

// *** src/sfl_readme_none.sv ***
// Companion note for the serial status flag block; all logic is in sfl_status
`default_nettype none
`default_nettype wire

// *** src/sfl_status.sv ***
// Serial peripheral status flags with Avalon-MM register access
`default_nettype none
module sfl_status
  import sfl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire sfl_link_t   link_in,
  output logic             miso_o,
  output logic             miso_oe,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Link synchronisers
  // ----------------------------------------------------------------
  sfl_link_t sync1_q;   // First stage, read only by second
  sfl_link_t sync2_q;   // Settled copy of the pins
  sfl_link_t sync3_q;   // Previous settled copy, for edges

  // Three stages; only the last two feed logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= LINK_IDLE;
      sync2_q <= LINK_IDLE;
      sync3_q <= LINK_IDLE;
    end else begin
      sync1_q <= link_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  wire logic sck_rise = sync2_q.sck & ~sync3_q.sck;
  wire logic sck_fall = ~sync2_q.sck & sync3_q.sck;
  wire logic ss_act   = ~sync2_q.ss_n;

  // ----------------------------------------------------------------
  // Bus handshake: one wait state per access
  // ----------------------------------------------------------------
  sfl_bus_t   bus_q;     // Handshake state
  sfl_bus_t   bus_d;     // Next handshake state
  logic [7:0] rdata_q;   // Read data captured in the wait cycle

  wire logic req    = avs_read | avs_write;
  wire logic accept = req & (bus_q == BUS_ACK);
  wire logic rd_acc = accept & avs_read;
  wire logic wr_acc = accept & avs_write;
  wire logic [7:0] wdata = avs_writedata[7:0];

  // Next state of the handshake
  always_comb begin
    case (bus_q)
      BUS_IDLE: bus_d = req ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  bus_d = BUS_IDLE;
      default:  bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_q <= BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  assign avs_waitrequest = req & (bus_q != BUS_ACK);
  assign avs_readdata    = {24'h000000, rdata_q};

  // Address decode
  wire logic sel_ctrl  = (avs_address == IDX_CTRL);
  wire logic sel_stat  = (avs_address == IDX_STATUS);
  wire logic sel_match = (avs_address == IDX_MATCH);
  wire logic sel_data  = (avs_address == IDX_DATA);
  wire logic sel_istat = (avs_address == IDX_INT_STAT);
  wire logic sel_imask = (avs_address == IDX_INT_MASK);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  sfl_ctrl_t         ctrl_q;      // Mode and fault detection setup
  logic [7:0]        match_val_q; // Value compared with received data
  logic [INT_W-1:0]  int_mask_q;  // Interrupt enables

  // Plain storage registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q      <= BYTE_RST;
      match_val_q <= BYTE_RST;
      int_mask_q  <= STAT_RSVD;
    end else begin
      if (wr_acc & sel_ctrl)  ctrl_q      <= wdata;
      if (wr_acc & sel_match) match_val_q <= wdata;
      if (wr_acc & sel_imask) int_mask_q  <= wdata[INT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Serial shifter (slave role)
  // ----------------------------------------------------------------
  logic [2:0] cnt_q;     // Bits received in this frame
  logic [7:0] sh_rx_q;   // Receive shift register
  logic [7:0] sh_tx_q;   // Transmit shift register, rotating
  logic [7:0] rx_buf_q;  // Receive buffer
  logic [7:0] tx_buf_q;  // Transmit buffer
  logic       tx_full_q; // Transmit buffer holds queued data
  logic       rx_done_q; // Completion one cycle late, for match

  // Only the slave role shifts; the master role only watches faults
  wire logic shifting = ss_act & ~ctrl_q.master_select;
  wire logic rx_done  = shifting & sck_rise & (cnt_q == LAST_BIT);
  wire logic [7:0] rx_next = {sh_rx_q[6:0], sync2_q.mosi};
  // Queued data moves when idle or at the end of a frame
  wire logic tx_move  = tx_full_q & (~ss_act | rx_done);
  // Seven turns on falls, the eighth at completion restores the byte
  wire logic tx_rot   = rx_done | (shifting & sck_fall & (cnt_q != 3'h0));

  // Shift on clock edges; rotation resends old data if none queued
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q    <= 3'h0;
      sh_rx_q  <= BYTE_RST;
      sh_tx_q  <= BYTE_RST;
      rx_buf_q <= BYTE_RST;
    end else begin
      if (!shifting) begin
        cnt_q <= 3'h0;
      end else if (sck_rise) begin
        cnt_q   <= cnt_q + 3'h1;
        sh_rx_q <= rx_next;
      end
      if (rx_done) rx_buf_q <= rx_next;
      if (tx_move) begin
        sh_tx_q <= tx_buf_q;
      end else if (tx_rot) begin
        // A load at completion wins, so new data is never turned
        sh_tx_q <= {sh_tx_q[6:0], sh_tx_q[7]};
      end
    end
  end

  // Pin outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      miso_o  <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_o  <= sh_tx_q[7];
      miso_oe <= shifting;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and their read-then-act arms
  // ----------------------------------------------------------------
  logic rxf_q,  rxf_arm_q;    // Receive-full and its arm
  logic mtf_q,  mtf_arm_q;    // Match flag and its arm
  logic txe_arm_q;            // Status read saw transmit empty
  logic mflt_q, mflt_arm_q;   // Mode fault and its arm

  // Arms come from the status value the read really returned
  wire logic stat_rd  = rd_acc & sel_stat;
  wire logic data_rd  = rd_acc & sel_data;
  wire logic data_wr  = wr_acc & sel_data;
  wire logic stat_wr  = wr_acc & sel_stat;

  wire logic rxf_clr  = data_rd & rxf_arm_q;
  wire logic mtf_evt  = rx_done_q & (rx_buf_q == match_val_q);
  wire logic mtf_clr  = stat_wr & wdata[MATCH_BIT] & mtf_arm_q;
  // A data write without the arm is ignored
  wire logic tx_load  = data_wr & txe_arm_q;
  wire logic fault    = ctrl_q.master_select
                      & ctrl_q.fault_detect_enable
                      & ~ctrl_q.select_output_enable & ss_act;
  wire logic mflt_clr = wr_acc & sel_ctrl & mflt_arm_q;

  // Set always wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxf_q     <= 1'b0;
      mtf_q     <= 1'b0;
      mflt_q    <= 1'b0;
      tx_full_q <= 1'b0;
      rx_done_q <= 1'b0;
    end else begin
      rxf_q     <= rx_done | (rxf_q & ~rxf_clr);
      mtf_q     <= mtf_evt | (mtf_q & ~mtf_clr);
      mflt_q    <= fault | (mflt_q & ~mflt_clr);
      tx_full_q <= tx_load | (tx_full_q & ~tx_move);
      rx_done_q <= rx_done;
    end
  end

  // Arms are set by a status read and spent by the next action
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxf_arm_q  <= 1'b0;
      mtf_arm_q  <= 1'b0;
      txe_arm_q  <= 1'b0;
      mflt_arm_q <= 1'b0;
      tx_buf_q   <= BYTE_RST;
    end else begin
      rxf_arm_q  <= (stat_rd & rdata_q[RXF_BIT])
                  | (rxf_arm_q & ~data_rd);
      mtf_arm_q  <= (stat_rd & rdata_q[MATCH_BIT])
                  | (mtf_arm_q & ~stat_wr);
      txe_arm_q  <= (stat_rd & rdata_q[TXE_BIT])
                  | (txe_arm_q & ~data_wr);
      mflt_arm_q <= (stat_rd & rdata_q[FAULT_BIT])
                  | (mflt_arm_q & ~(wr_acc & sel_ctrl));
      if (tx_load) tx_buf_q <= wdata;
    end
  end

  // Status byte; writes to it reach only the match clear
  wire logic [7:0] status_byte = {rxf_q, mtf_q, ~tx_full_q, mflt_q,
                                  STAT_RSVD};

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [INT_W-1:0] int_stat_q;  // Sticky event bits

  wire logic [INT_W-1:0] int_evt = {fault & ~mflt_q, tx_move,
                                    mtf_evt, rx_done};
  wire logic [INT_W-1:0] int_clr = (wr_acc & sel_istat)
                                 ? wdata[INT_W-1:0] : STAT_RSVD;

  // Write one to clear, new event wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      int_stat_q <= STAT_RSVD;
      irq        <= 1'b0;
    end else begin
      int_stat_q <= int_evt | (int_stat_q & ~int_clr);
      irq        <= |(int_stat_q & int_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data: captured in the wait cycle, held for the accept edge
  // ----------------------------------------------------------------
  wire logic [7:0] rd_mux =
      sel_ctrl  ? ctrl_q :
      sel_stat  ? status_byte :
      sel_match ? match_val_q :
      sel_data  ? rx_buf_q :
      sel_istat ? {4'h0, int_stat_q} :
      sel_imask ? {4'h0, int_mask_q} : BYTE_RST;  // Unmapped reads 0

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= BYTE_RST;
    end else if (avs_read & (bus_q == BUS_IDLE)) begin
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  status_ro_a: assert property (
    (stat_wr && !rx_done && !fault) |=>
      (rxf_q == $past(rxf_q)) && (mflt_q == $past(mflt_q)))
    else $error("status write changed a flag");
  reserved_zero_a: assert property (
    stat_rd |-> (avs_readdata[3:0] == 4'h0))
    else $error("reserved status bits not zero");
  rx_set_a: assert property (
    rx_done |=> rxf_q ##1 (rxf_q || $past(rxf_clr)))
    else $error("receive-full did not set");
  rx_hold_a: assert property (
    (rxf_q && !(data_rd && rxf_arm_q)) |=> rxf_q)
    else $error("receive-full cleared without sequence");
  match_rise_a: assert property (
    $rose(mtf_q) |-> $past(rx_done_q) && rxf_q)
    else $error("match flag rose without completion");
  match_clear_a: assert property (
    (mtf_clr && !mtf_evt) |=> !mtf_q)
    else $error("match flag not cleared");
  tx_empty_a: assert property (
    tx_load |=> !status_byte[TXE_BIT])
    else $error("transmit-empty wrong after load");
  fault_set_a: assert property (
    fault |=> mflt_q)
    else $error("mode fault not raised");
  irq_level_a: assert property (
    (|(int_stat_q & int_mask_q)) |=> irq)
    else $error("interrupt not raised");
endmodule // sfl_status
`default_nettype wire

// *** tb/sfl_link_model.sv ***
// Behavioural serial master standing on the far side of the status block
`default_nettype none
module sfl_link_model
  import sfl_pkg::*;
(
  output var sfl_link_t link,
  input  wire logic     miso,
  input  wire logic     miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int HALF = 200;  // Half of the 400 ns link period

  // Deselected, clock low: the clock stands still between frames
  initial link = LINK_IDLE;

  // One frame of eight bits, msb first, data sampled on the rise
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    link.ss_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      link.mosi = tx[i];
      #HALF link.sck = 1'b1;
      // An undriven line reads inverted so a silent slave is caught
      rx[i] = miso_oe ? miso : ~miso;
      #HALF link.sck = 1'b0;
    end
    // Released data line flips so no stale bit can pass for valid
    link.mosi = ~link.mosi;
    #HALF link.ss_n = 1'b1;
  endtask

  // Select pulled low with no clock, as a rival master would do
  task automatic pull_select(input int len);
    link.ss_n = 1'b0;
    #len link.ss_n = 1'b1;
  endtask
endmodule // sfl_link_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the serial status flag block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfl_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        sys_clk;          // 20 MHz bus clock
  logic        rst;              // Synchronous reset, active high
  logic [2:0]  avs_address;      // Word index
  logic        avs_read;         // Read request
  logic        avs_write;        // Write request
  logic [31:0] avs_writedata;    // Write data
  logic [31:0] avs_readdata;     // Read data
  logic        avs_waitrequest;  // Wait state
  sfl_link_t   link;             // Link from the far master
  logic        miso_o;           // Serial data back
  logic        miso_oe;          // Serial data driven
  logic        irq;              // Level interrupt
  logic [7:0]  rx;               // Byte seen by the far master
  int          mismatches;       // Failed comparisons
  int          num_checks;       // All comparisons

  sfl_status dut_u (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link_in(link), .miso_o(miso_o), .miso_oe(miso_oe), .irq(irq));

  sfl_link_model link_u (.link(link), .miso(miso_o), .miso_oe(miso_oe));

  // Clock: 50 ns period
  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count; unknowns never match
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus access; waitrequest and read data are taken at a rising edge
  task automatic bus(input logic w, input logic [2:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address   <= idx;
    avs_writedata <= {24'h000000, d};
    avs_read      <= ~w;
    avs_write     <= w;
    // Wait for the accept edge; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    // Release only after the accept edge
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [2:0] idx, input logic [7:0] e,
                    input string what);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(what, q, {24'h000000, e});
  endtask

  // Frame on the link, then time for sync and flag update
  task automatic xfer(input logic [7:0] tx);
    // Start off the sampling edge so pins never race the flops
    @(negedge sys_clk);
    link_u.frame(tx, rx);
    repeat (10) @(posedge sys_clk);
  endtask

  // Interrupt is registered: let it settle two cycles
  task automatic irq_is(input logic e);
    repeat (2) @(negedge sys_clk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  // Single place where the run ends
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: the tests need well under a millisecond
  // ----------------------------------------------------------------
  initial begin
    #3000000;
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    mismatches = 0;
    num_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(IDX_STATUS, 8'h20, "status reset");
    rd(3'h1, 8'h00, "unmapped");
    wr(IDX_INT_MASK, 8'h01);
    wr(IDX_MATCH, 8'hA5);
    rd(IDX_MATCH, 8'hA5, "match value");
    rd(IDX_INT_MASK, 8'h01, "int mask");
    // Received byte equals the match value
    xfer(8'hA5);
    rd(IDX_STATUS, 8'hE0, "status full match");
    irq_is(1'b1);
    check("miso_oe idle", {31'h0, miso_oe}, 32'h00000000);
    wr(IDX_INT_MASK, 8'h00);
    irq_is(1'b0);
    wr(IDX_INT_STAT, 8'h0F);
    wr(IDX_INT_MASK, 8'h01);
    irq_is(1'b0);
    rd(IDX_DATA, 8'hA5, "rx data");
    rd(IDX_STATUS, 8'h60, "full cleared");
    // Write without bit 6 must not clear or set a flag; it only spends the match arm
    wr(IDX_STATUS, 8'hBF);
    rd(IDX_STATUS, 8'h60, "status write");
    wr(IDX_STATUS, 8'h40);
    rd(IDX_STATUS, 8'h20, "match cleared");
    // Data read without the status read first keeps the flag
    xfer(8'h3C);
    rd(IDX_DATA, 8'h3C, "rx data");
    rd(IDX_STATUS, 8'hA0, "full kept");
    rd(IDX_DATA, 8'h3C, "rx data");
    rd(IDX_STATUS, 8'h20, "full cleared");
    wr(IDX_INT_STAT, 8'h01);
    irq_is(1'b0);
    // Queue a byte after the status read that showed room
    wr(IDX_DATA, 8'h96);
    xfer(8'h00);
    check("miso byte", {24'h000000, rx}, 32'h00000096);
    rd(IDX_STATUS, 8'hA0, "tx moved");
    rd(IDX_DATA, 8'h00, "rx data");
    // Master with fault detect, select output off
    wr(IDX_CTRL, 8'h06);
    rd(IDX_CTRL, 8'h06, "ctrl");
    @(negedge sys_clk);
    link_u.pull_select(500);
    repeat (10) @(posedge sys_clk);
    rd(IDX_STATUS, 8'h30, "mode fault");
    rd(IDX_INT_STAT, 8'h0D, "int status");
    irq_is(1'b1);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_STATUS, 8'h20, "fault cleared");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
